// >>> core/ecs_map.svh
// Constants for the embedded-clock serializer: widths, symbol values, counts.
// Assumes it is included by bare name; definitions only.
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH

`define ECS_DATA_BITS 10
`define ECS_FRAME_BITS 12
`define ECS_START_BIT 1'b1
`define ECS_STOP_BIT 1'b0
`define ECS_SYNC_DATA 10'h01F
`define ECS_SYNC_MIN_SYMBOLS 1024
`define ECS_SYNC_CNT_BITS 11
`define ECS_LOCK_MIN_PERIODS 510
`define ECS_LOCK_MAX_PERIODS 513
`define ECS_LOCK_PERIODS 512
`define ECS_LOCK_CNT_BITS 10
`define ECS_PIPE_DEPTH 2

`endif

// >>> core/ecs_pkg.sv
// Types shared by the embedded-clock serializer files.
// Assumes ecs_map.svh is on the include path.
`include "ecs_map.svh"

package ecs_pkg;

  typedef enum logic [1:0] {
    ECS_SLEEP,
    ECS_LOCKING,
    ECS_RUN
  } ecs_mode_t;

  typedef struct packed {
    logic stop;
    logic [`ECS_DATA_BITS-1:0] data;
    logic start;
  } ecs_frame_t;

  typedef struct packed {
    logic wclk;
    logic edge_sel;
    logic req_a;
    logic req_b;
    logic oe;
    logic awake;
    logic [`ECS_DATA_BITS-1:0] data;
  } ecs_pins_t;

  typedef struct packed {
    ecs_pins_t meta;
    ecs_pins_t pins;
    logic wclk_prev;
    logic req_prev;
    ecs_mode_t mode;
    logic [`ECS_SYNC_CNT_BITS-1:0] sync_cnt;
    ecs_frame_t frame;
    logic strobe;
    logic oe_n;
  } ecs_state_t;

  typedef struct packed {
    logic [`ECS_LOCK_CNT_BITS-1:0] cnt;
    logic locked;
  } ecs_lock_t;

endpackage

// >>> core/ecs_lock_timer.sv
// Frequency multiplier lock model: counts word clock periods after wake.
// Assumes tick is a one-cycle pulse per synchronised word clock rising edge.
`timescale 1ns/1ns
`include "ecs_map.svh"

module ecs_lock_timer #(
  parameter int LOCK_EDGES = `ECS_LOCK_PERIODS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic tick,
  // Status
  output logic locked
);

  ecs_pkg::ecs_lock_t s_ff;
  ecs_pkg::ecs_lock_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    // Sleep stops the multiplier, so lock is lost at once
    if (!run) begin
      nxt_s = '0;
    end else if (tick && !s_ff.locked) begin
      // Lock lands inside the 510..513 period window
      if (s_ff.cnt == `ECS_LOCK_CNT_BITS'(LOCK_EDGES - 1)) begin
        nxt_s.locked = 1'b1;
      end
      nxt_s.cnt = s_ff.cnt + `ECS_LOCK_CNT_BITS'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign locked = s_ff.locked;

  chk_lock_after_count: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(s_ff.locked) |-> $past(tick) && $past(s_ff.cnt) == `ECS_LOCK_CNT_BITS'(LOCK_EDGES - 1))
    else $error("lock raised before the full period count");

endmodule

// >>> core/ecs_serializer.sv
// 10:1 embedded-clock serializer core, framing each latched word unless a sync symbol takes its slot.
// Assumes all inputs but clock and sys_rst are asynchronous pins; the word clock is sampled.
`timescale 1ns/1ns
`include "ecs_map.svh"

module ecs_serializer #(
  parameter int LOCK_EDGES = `ECS_LOCK_PERIODS,
  parameter int SYNC_MIN = `ECS_SYNC_MIN_SYMBOLS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Parallel word side
  input wire logic transmit_word_clock,
  input wire logic latch_edge_select,
  input wire logic [`ECS_DATA_BITS-1:0] parallel_data,
  // Control pins
  input wire logic pattern_request_a,
  input wire logic pattern_request_b,
  input wire logic serial_output_enable,
  input wire logic sleep_request_n,
  // Serial side
  output ecs_pkg::ecs_frame_t frame_word,
  output logic frame_strobe,
  output logic serial_oe_n,
  // Status
  output logic multiplier_locked,
  output logic sync_sending
);

  ecs_pkg::ecs_state_t s_ff;
  ecs_pkg::ecs_state_t nxt_s;
  ecs_pkg::ecs_pins_t raw_pins;
  logic locked;
  logic wclk_rise;
  logic wclk_fall;
  logic latch;
  logic req_now;
  logic sync_due;

  // Only the second synchroniser stage feeds logic; meta is read only to load pins
  assign raw_pins.wclk = transmit_word_clock;
  assign raw_pins.edge_sel = latch_edge_select;
  assign raw_pins.req_a = pattern_request_a;
  assign raw_pins.req_b = pattern_request_b;
  assign raw_pins.oe = serial_output_enable;
  assign raw_pins.awake = sleep_request_n;
  assign raw_pins.data = parallel_data;

  // Data rides the same two stages as the clock, so alignment holds
  assign wclk_rise = s_ff.pins.wclk && !s_ff.wclk_prev;
  assign wclk_fall = !s_ff.pins.wclk && s_ff.wclk_prev;
  assign latch = s_ff.pins.edge_sel ? wclk_rise : wclk_fall;
  assign req_now = s_ff.pins.req_a || s_ff.pins.req_b;
  assign sync_due = req_now || (s_ff.sync_cnt != '0);

  ecs_lock_timer #(
    .LOCK_EDGES(LOCK_EDGES)
  ) u_lock (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(s_ff.pins.awake),
    .tick(wclk_rise),
    .locked(locked)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = raw_pins;
    nxt_s.pins = s_ff.meta;
    nxt_s.wclk_prev = s_ff.pins.wclk;
    nxt_s.req_prev = req_now;
    nxt_s.strobe = 1'b0;
    case (s_ff.mode)
      ecs_pkg::ECS_SLEEP: begin
        if (s_ff.pins.awake) begin
          nxt_s.mode = ecs_pkg::ECS_LOCKING;
        end
      end
      ecs_pkg::ECS_LOCKING: begin
        if (locked) begin
          nxt_s.mode = ecs_pkg::ECS_RUN;
        end
      end
      ecs_pkg::ECS_RUN: begin
        if (!locked) begin
          nxt_s.mode = ecs_pkg::ECS_LOCKING;
        end
      end
      default: begin
        nxt_s.mode = ecs_pkg::ECS_SLEEP;
      end
    endcase
    if (!s_ff.pins.awake) begin
      nxt_s.mode = ecs_pkg::ECS_SLEEP;
      // A request held through sleep still owes a full burst after wake
      nxt_s.sync_cnt = req_now ? `ECS_SYNC_CNT_BITS'(SYNC_MIN) : '0;
    end
    // A fresh request arms a full burst; later ones extend it
    if (req_now && !s_ff.req_prev) begin
      nxt_s.sync_cnt = `ECS_SYNC_CNT_BITS'(SYNC_MIN);
    end
    if (s_ff.mode == ecs_pkg::ECS_RUN && latch) begin
      nxt_s.strobe = 1'b1;
      nxt_s.frame.start = `ECS_START_BIT;
      nxt_s.frame.stop = `ECS_STOP_BIT;
      if (sync_due) begin
        // Sync symbols let the receiver phase-lock
        nxt_s.frame.data = `ECS_SYNC_DATA;
        if (s_ff.sync_cnt != '0 && !(req_now && !s_ff.req_prev)) begin
          nxt_s.sync_cnt = s_ff.sync_cnt - `ECS_SYNC_CNT_BITS'(1);
        end else if (req_now && !s_ff.req_prev) begin
          nxt_s.sync_cnt = `ECS_SYNC_CNT_BITS'(SYNC_MIN - 1);
        end
      end else begin
        nxt_s.frame.data = s_ff.pins.data;
      end
    end
    // Output drives only when enabled, awake and locked
    nxt_s.oe_n = !(s_ff.pins.oe && s_ff.pins.awake && s_ff.mode == ecs_pkg::ECS_RUN);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '{default: '0, mode: ecs_pkg::ECS_SLEEP, oe_n: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign frame_word = s_ff.frame;
  assign frame_strobe = s_ff.strobe;
  assign serial_oe_n = s_ff.oe_n;
  assign multiplier_locked = locked;
  assign sync_sending = s_ff.sync_cnt != '0 || req_now;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Checks judge registered outputs one cycle after the state that decides them; chk_sleep_hiz checks the lock one cycle later still
  chk_frame_clock_bits: assert property (
    frame_strobe |-> frame_word.start == 1'b1 && frame_word.stop == 1'b0)
    else $error("frame lacks its two clock bits");

  chk_sync_on_request: assert property (
    s_ff.mode == ecs_pkg::ECS_RUN && latch && req_now
    |=> frame_strobe && frame_word.data == `ECS_SYNC_DATA)
    else $error("request high but data frame sent");

  chk_no_frame_unlocked: assert property (
    !locked && s_ff.mode != ecs_pkg::ECS_RUN |=> !frame_strobe)
    else $error("frame sent before multiplier lock");

  chk_burst_armed: assert property (
    req_now && !s_ff.req_prev |=> s_ff.sync_cnt >= `ECS_SYNC_CNT_BITS'(SYNC_MIN - 1))
    else $error("sync burst not armed on request");

  chk_burst_continues: assert property (
    s_ff.mode == ecs_pkg::ECS_RUN && s_ff.pins.awake && latch && s_ff.sync_cnt != '0
    |=> frame_word.data == `ECS_SYNC_DATA)
    else $error("sync burst cut short");

  chk_edge_choice: assert property (
    s_ff.mode == ecs_pkg::ECS_RUN && s_ff.pins.awake
    && (s_ff.pins.edge_sel ? wclk_fall : wclk_rise) |=> !frame_strobe)
    else $error("word latched on the wrong edge");

  chk_oe_disable: assert property (
    !s_ff.pins.oe |=> serial_oe_n)
    else $error("output driven while disabled");

  chk_sleep_hiz: assert property (
    !s_ff.pins.awake |=> serial_oe_n ##1 !multiplier_locked)
    else $error("sleep did not stop the multiplier");

  chk_data_path: assert property (
    s_ff.mode == ecs_pkg::ECS_RUN && s_ff.pins.awake && latch && !sync_due
    |=> frame_strobe && frame_word.data == $past(s_ff.pins.data))
    else $error("latched word not carried in frame");

  chk_burst_no_drain: assert property (
    s_ff.sync_cnt != '0 && s_ff.pins.awake && !(req_now && !s_ff.req_prev)
    |=> s_ff.sync_cnt == $past(s_ff.sync_cnt)
    || (frame_strobe && frame_word.data == `ECS_SYNC_DATA))
    else $error("sync burst counted a symbol it never sent");

  chk_sleep_keeps_burst: assert property (
    !s_ff.pins.awake && s_ff.mode != ecs_pkg::ECS_RUN && req_now
    |=> s_ff.sync_cnt == `ECS_SYNC_CNT_BITS'(SYNC_MIN))
    else $error("held request lost its burst in sleep");

  chk_oe_enable: assert property (
    s_ff.pins.oe && s_ff.pins.awake && s_ff.mode == ecs_pkg::ECS_RUN |=> !serial_oe_n)
    else $error("output stayed high impedance while enabled");

  chk_strobe_single: assert property (
    frame_strobe |=> !frame_strobe)
    else $error("two frames from one word clock edge");

  chk_frame_holds: assert property (
    !frame_strobe |-> $stable(frame_word))
    else $error("frame word changed without a strobe");

  chk_run_needs_lock: assert property (
    s_ff.mode == ecs_pkg::ECS_RUN |-> locked)
    else $error("running without multiplier lock");

endmodule

// >>> test/ecs_rx_model.sv
// Receiver model: takes frames, flags loss of lock, recovers words.
// Assumes frames arrive as the serializer's frame word and strobe.
`timescale 1ns/1ns
module ecs_rx_model #(
  parameter int LOCK_FRAMES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial side
  input wire ecs_pkg::ecs_frame_t frame_word,
  input wire logic frame_strobe,
  input wire logic serial_oe_n,
  // Receiver pins
  output logic lock_loss,
  output logic [9:0] receiver_parallel_out
);
  int good;
  always_ff @(posedge clock) begin
    if (sys_rst || serial_oe_n) begin
      lock_loss <= 1'b1;
      good <= 0;
      receiver_parallel_out <= sys_rst ? 10'h155 : ~receiver_parallel_out;
    end else if (frame_strobe && frame_word.start && !frame_word.stop) begin
      if (!lock_loss)
        receiver_parallel_out <= frame_word.data;
      else if (good + 1 >= LOCK_FRAMES)
        lock_loss <= 1'b0;
      good <= good + 1;
    end else if (lock_loss)
      // Unlocked output is junk, flipping on every cycle without a frame rather than holding a stale word
      receiver_parallel_out <= ~receiver_parallel_out;
  end
endmodule

// >>> test/ecs_serializer_bench.sv
// Bench for the serializer: words, sync bursts, output enable and sleep.
// Assumes the receiver model on the serial side, its flag on request b.
`timescale 1ns/1ns
module ecs_serializer_bench;
  localparam int LOCK = 8;
  localparam int SMIN = 16;
  logic clock = 0, sys_rst = 1, wclk = 0, sel = 1, req_a = 0, oe = 1, wake = 1;
  logic [9:0] din = 10'h2A5;
  ecs_pkg::ecs_frame_t fw;
  logic strobe, oe_n, locked, sending, lock_loss;
  logic [9:0] rx_out;
  int miscompares = 0, samples_checked = 0, n, k, sync_seen = 0, burst_base = 0;
  ecs_serializer #(.LOCK_EDGES(LOCK), .SYNC_MIN(SMIN)) dut (.clock(clock), .sys_rst(sys_rst),
    .transmit_word_clock(wclk), .latch_edge_select(sel), .parallel_data(din),
    .pattern_request_a(req_a), .pattern_request_b(lock_loss),
    .serial_output_enable(oe), .sleep_request_n(wake), .frame_word(fw), .frame_strobe(strobe),
    .serial_oe_n(oe_n), .multiplier_locked(locked), .sync_sending(sending));
  ecs_rx_model rx (.clock(clock), .sys_rst(sys_rst), .frame_word(fw), .frame_strobe(strobe),
    .serial_oe_n(oe_n), .lock_loss(lock_loss), .receiver_parallel_out(rx_out));
  initial forever #20 clock = ~clock;
  // Counts every sync symbol, so a burst is judged from its very start
  always @(negedge clock) begin
    if (strobe === 1'b1 && fw === 12'h03F) begin
      sync_seen++;
    end
  end
  // Word clock offset so its edges never meet the system clock edges
  initial begin
    #7;
    forever #160 wclk = ~wclk;
  end
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic next_frame(input int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (strobe !== 1'b1 && n < lim);
    if (strobe !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic wait_lock();
    n = 0;
    while (locked !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("lock time", 12'h001, {11'h000, n >= (LOCK - 1) * 8 && n <= (LOCK + 2) * 8});
    if (locked !== 1'b1) tally_and_finish();
  endtask
  // Short window catches a latch on the wrong word clock edge
  task automatic send_word(input logic [9:0] d);
    if (sel) @(negedge wclk); else @(posedge wclk);
    @(negedge clock);
    din = d;
    if (sel) @(posedge wclk); else @(negedge wclk);
    next_frame(6);
    check("frame", {1'b0, d, 1'b1}, fw);
    @(negedge clock);
    check("receiver word", {2'b00, d}, {2'b00, rx_out});
  endtask
  task automatic sync_run(input string name);
    k = 0;
    do begin
      next_frame(12);
      k++;
    end while (fw === 12'h03F && k < 200);
    check("burst length", 12'h001, {11'h000, sync_seen - burst_base >= SMIN});
    check("frame after burst", {1'b0, din, 1'b1}, fw);
    check("receiver flag", 12'h000, {11'h000, lock_loss});
    if (fw === 12'h03F) tally_and_finish();
    $display("test %s done", name);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    check("output enable in reset", 12'h001, {11'h000, oe_n});
    sys_rst = 0;
    wait_lock();
    check("sync active", 12'h001, {11'h000, sending});
    sync_run("startup");
    for (int s = 1; s >= 0; s--) begin
      sel = s[0];
      send_word(10'h001);
      send_word(10'h3FE);
      send_word(10'h2A5);
    end
    $display("test words done");
    burst_base = sync_seen;
    req_a = 1;
    // Six frames keep the request up past five word clock periods
    repeat (6) next_frame(12);
    check("sync on request a", 12'h001, {11'h000, sending});
    req_a = 0;
    sync_run("request");
    burst_base = sync_seen;
    oe = 0;
    repeat (4) @(negedge clock);
    check("output off", 12'h001, {11'h000, oe_n});
    check("receiver lost", 12'h001, {11'h000, lock_loss});
    oe = 1;
    repeat (4) @(negedge clock);
    check("output on", 12'h000, {11'h000, oe_n});
    sync_run("enable");
    burst_base = sync_seen;
    wake = 0;
    k = 0;
    repeat (40) begin
      @(negedge clock);
      k += (strobe === 1'b1);
    end
    check("asleep", 12'h003, {9'h000, locked, oe_n, k == 0});
    wake = 1;
    wait_lock();
    sync_run("wake");
    tally_and_finish();
  end
endmodule
